// ### logic/bcc_unit.sv
// Functional notes
// - Branch-if-lower adds offset to PC only when carry is one.
// - Branch-if-lower and branch-on-carry-set share one code and behaviour.
// - Branch-if-lower-or-same taken when carry OR zero is one.
// - Signed less-than branch taken when negative XOR overflow is one.
// - Branch-if-minus taken when negative flag is one.
// - Branch-if-not-equal taken when zero flag is zero.
// - Branch-if-plus taken when negative flag is zero.
// - Unconditional branch always loads PC plus signed offset.
// - Never-branch consumes offset, keeps PC sequential and flags untouched.
// - Relative call pushes return low then high byte, then PC plus offset.
// - Branch-if-no-overflow taken when overflow flag is zero.
// - Branch-if-overflow taken when overflow flag is one.
// - Branches and relative call never change condition-code flags.
// - Clear writes zero; N V C cleared, Z set, H kept.
// - Memory clear reads the effective address before writing zero.
// - 8-bit compare subtracts memory from accumulator, sets N Z V C, no writeback.
// - Compare carry is the borrow, inverse of adder carry out.
// - 16-bit compare subtracts high-first memory word, sets N Z V C, keeps H.
// - 16-bit compare writes nothing except auto-step index register.
// - Clear in inherent, extended, direct, indexed forms; branches are relative.
//
// Added by the designer: strobed register access and the register offsets.
module bcc_unit (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic req_valid,
  input wire bcc_pkg::bcc_req_t req,
  output logic req_ready,
  output logic done,
  output bcc_pkg::bcc_res_t res,
  output logic mem_re,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  bcc_pkg::bcc_state_t state_r;
  bcc_pkg::bcc_state_t state_nxt;
  bcc_pkg::bcc_req_t hold_r;
  bcc_pkg::bcc_req_t hold_nxt;
  bcc_pkg::bcc_res_t res_r;
  bcc_pkg::bcc_res_t res_nxt;
  logic ready_r;
  logic ready_nxt;
  logic done_r;
  logic done_nxt;
  logic mem_re_r;
  logic mem_re_nxt;
  logic mem_we_r;
  logic mem_we_nxt;
  logic [15:0] mem_addr_r;
  logic [15:0] mem_addr_nxt;
  logic [7:0] mem_wdata_r;
  logic [7:0] mem_wdata_nxt;

  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic taken_r;
  logic taken_nxt;
  logic illegal_r;
  logic illegal_nxt;
  logic [15:0] target_r;
  logic [15:0] target_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  logic accept;
  logic cond_taken;
  logic cond_known;
  logic [15:0] offset_ext;
  logic [15:0] branch_target;
  logic [15:0] held_target;
  logic [15:0] sp_dec1;
  logic [15:0] sp_dec2;
  logic [7:0] clr_cc;
  logic [7:0] cmp_cc;
  bcc_pkg::bcc_flags_t cmp_flags;
  logic is_cmp16;

  ////////////////////////////////////////////////////////////////////////
  // Datapath helpers

  assign accept = req_valid & ready_r & ctrl_r[bcc_pkg::CTRL_EN];

  assign offset_ext = req.long_form ? req.offset : {{8{req.offset[7]}}, req.offset[7:0]};
  assign branch_target = req.pc + offset_ext;
  assign held_target = hold_r.pc +
    (hold_r.long_form ? hold_r.offset : {{8{hold_r.offset[7]}}, hold_r.offset[7:0]});
  assign sp_dec1 = req.sp - bcc_pkg::STACK_STEP;
  assign sp_dec2 = hold_r.sp - bcc_pkg::STACK_STEP2;
  assign is_cmp16 = (req.op == bcc_pkg::BCC_OP_CMP16);

  bcc_cond_eval u_cond (
    .cond(req.cond),
    .cc(req.cc),
    .taken(cond_taken),
    .known(cond_known)
  );

  bcc_cmp_alu u_alu (
    .wide(is_cmp16),
    .reg_val(req.operand_reg),
    .mem_val(req.mem_operand),
    .flags(cmp_flags)
  );

  // Clear result on flags: only N Z V C move
  always_comb begin
    clr_cc = hold_r.cc;
    if (state_r == bcc_pkg::BCC_ST_IDLE) begin
      clr_cc = req.cc;
    end
    clr_cc[bcc_pkg::CC_N] = 1'b0;
    clr_cc[bcc_pkg::CC_Z] = 1'b1;
    clr_cc[bcc_pkg::CC_V] = 1'b0;
    clr_cc[bcc_pkg::CC_C] = 1'b0;
  end

  // Undefined H on byte compare is left as it was; costs nothing
  always_comb begin
    cmp_cc = req.cc;
    cmp_cc[bcc_pkg::CC_N] = cmp_flags.n;
    cmp_cc[bcc_pkg::CC_Z] = cmp_flags.z;
    cmp_cc[bcc_pkg::CC_V] = cmp_flags.v;
    cmp_cc[bcc_pkg::CC_C] = cmp_flags.c;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    res_nxt = '0;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    mem_re_nxt = 1'b0;
    mem_we_nxt = 1'b0;
    mem_addr_nxt = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    taken_nxt = taken_r;
    illegal_nxt = illegal_r;
    target_nxt = target_r;
    case (state_r)
      bcc_pkg::BCC_ST_IDLE: begin
        ready_nxt = 1'b1;
        if (accept) begin
          hold_nxt = req;
          case (req.op)
            bcc_pkg::BCC_OP_BRANCH: begin
              // Flags never written: cc_we stays low
              res_nxt.pc_load = cond_taken;
              res_nxt.pc_val = cond_taken ? branch_target : req.pc;
              taken_nxt = cond_taken;
              target_nxt = branch_target;
              illegal_nxt = ~cond_known;
              done_nxt = 1'b1;
            end
            bcc_pkg::BCC_OP_CALL: begin
              // Push low byte first at SP-1
              mem_we_nxt = 1'b1;
              mem_addr_nxt = sp_dec1;
              mem_wdata_nxt = req.pc[7:0];
              ready_nxt = 1'b0;
              illegal_nxt = 1'b0;
              state_nxt = bcc_pkg::BCC_ST_PUSH_LO;
            end
            bcc_pkg::BCC_OP_CLR_A,
            bcc_pkg::BCC_OP_CLR_B: begin
              res_nxt.acc_a_clr = (req.op == bcc_pkg::BCC_OP_CLR_A);
              res_nxt.acc_b_clr = (req.op == bcc_pkg::BCC_OP_CLR_B);
              res_nxt.cc_we = 1'b1;
              res_nxt.cc_val = clr_cc;
              illegal_nxt = (req.amode != bcc_pkg::BCC_AM_INHERENT);
              done_nxt = 1'b1;
            end
            bcc_pkg::BCC_OP_CLR_MEM: begin
              illegal_nxt = (req.amode == bcc_pkg::BCC_AM_INHERENT);
              if (req.amode == bcc_pkg::BCC_AM_INHERENT) begin
                done_nxt = 1'b1;
              end else begin
                // Dummy read of the target first
                mem_re_nxt = 1'b1;
                mem_addr_nxt = req.effective_address;
                ready_nxt = 1'b0;
                state_nxt = bcc_pkg::BCC_ST_CLR_RD;
              end
            end
            bcc_pkg::BCC_OP_CMP8,
            bcc_pkg::BCC_OP_CMP16: begin
              // No operand writeback; flags, plus the index register on an auto-step 16-bit compare
              res_nxt.cc_we = 1'b1;
              res_nxt.cc_val = cmp_cc;
              res_nxt.idx_we = is_cmp16 & req.auto_idx;
              res_nxt.idx_val = req.idx_new;
              illegal_nxt = 1'b0;
              done_nxt = 1'b1;
            end
            default: begin
              illegal_nxt = 1'b1;
              done_nxt = 1'b1;
            end
          endcase
        end
      end
      bcc_pkg::BCC_ST_CLR_RD: begin
        // Read data discarded; the write follows at once
        mem_we_nxt = 1'b1;
        mem_addr_nxt = hold_r.effective_address;
        mem_wdata_nxt = bcc_pkg::ZERO_BYTE;
        state_nxt = bcc_pkg::BCC_ST_CLR_WR;
      end
      bcc_pkg::BCC_ST_CLR_WR: begin
        res_nxt.cc_we = 1'b1;
        res_nxt.cc_val = clr_cc;
        done_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = bcc_pkg::BCC_ST_IDLE;
      end
      bcc_pkg::BCC_ST_PUSH_LO: begin
        mem_we_nxt = 1'b1;
        mem_addr_nxt = sp_dec2;
        mem_wdata_nxt = hold_r.pc[15:8];
        state_nxt = bcc_pkg::BCC_ST_PUSH_HI;
      end
      bcc_pkg::BCC_ST_PUSH_HI: begin
        // PC and SP update once both bytes are out; flags untouched
        res_nxt.pc_load = 1'b1;
        res_nxt.pc_val = held_target;
        res_nxt.sp_we = 1'b1;
        res_nxt.sp_val = sp_dec2;
        taken_nxt = 1'b1;
        target_nxt = held_target;
        done_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = bcc_pkg::BCC_ST_IDLE;
      end
      default: begin
        ready_nxt = 1'b1;
        state_nxt = bcc_pkg::BCC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= bcc_pkg::BCC_ST_IDLE;
      hold_r <= '0;
      res_r <= '0;
      ready_r <= 1'b0;
      done_r <= 1'b0;
      mem_re_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= bcc_pkg::ZERO_WORD;
      mem_wdata_r <= bcc_pkg::ZERO_BYTE;
      taken_r <= 1'b0;
      illegal_r <= 1'b0;
      target_r <= bcc_pkg::ZERO_WORD;
    end else if (ce) begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      res_r <= res_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      mem_re_r <= mem_re_nxt;
      mem_we_r <= mem_we_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      taken_r <= taken_nxt;
      illegal_r <= illegal_nxt;
      target_r <= target_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port

  always_comb begin
    ctrl_nxt = ctrl_r;
    count_nxt = count_r;
    rdata_nxt = bcc_pkg::ZERO_WORD;
    if (reg_wr && reg_addr == bcc_pkg::REG_CTRL) begin
      ctrl_nxt = reg_wdata;
    end
    // Counter write clears it; a completion in the same cycle still counts
    if (reg_wr && reg_addr == bcc_pkg::REG_COUNT) begin
      count_nxt = bcc_pkg::ZERO_WORD;
    end
    if (done_r) begin
      count_nxt = count_nxt + bcc_pkg::COUNT_STEP;
    end
    if (reg_rd) begin
      case (reg_addr)
        bcc_pkg::REG_STATUS: begin
          rdata_nxt[bcc_pkg::ST_BUSY] = ~ready_r;
          rdata_nxt[bcc_pkg::ST_TAKEN] = taken_r;
          rdata_nxt[bcc_pkg::ST_ILLEGAL] = illegal_r;
        end
        bcc_pkg::REG_CTRL: rdata_nxt = ctrl_r;
        bcc_pkg::REG_TARGET: rdata_nxt = target_r;
        bcc_pkg::REG_COUNT: rdata_nxt = count_r;
        default: rdata_nxt = bcc_pkg::ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r <= bcc_pkg::CTRL_RESET;
      count_r <= bcc_pkg::ZERO_WORD;
      rdata_r <= bcc_pkg::ZERO_WORD;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      count_r <= count_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign req_ready = ready_r;
  assign done = done_r;
  assign res = res_r;
  assign mem_re = mem_re_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign reg_rdata = rdata_r;

endmodule // bcc_unit

// ### logic/bcc_pkg.sv
package bcc_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned REG_DW = 16;

  // Condition-code bit positions
  localparam int unsigned CC_C = 0;
  localparam int unsigned CC_V = 1;
  localparam int unsigned CC_Z = 2;
  localparam int unsigned CC_N = 3;
  localparam int unsigned CC_H = 5;

  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [ADDR_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [ADDR_W-1:0] STACK_STEP = 16'h0001;
  localparam logic [ADDR_W-1:0] STACK_STEP2 = 16'h0002;

  // Register port map
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_TARGET = 2'h2;
  localparam logic [1:0] REG_COUNT = 2'h3;

  localparam int unsigned CTRL_EN = 0;
  localparam logic [REG_DW-1:0] CTRL_RESET = 16'h0001;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_TAKEN = 1;
  localparam int unsigned ST_ILLEGAL = 2;
  localparam logic [REG_DW-1:0] COUNT_STEP = 16'h0001;

  typedef enum logic [2:0] {
    BCC_OP_NONE = 3'h0,
    BCC_OP_BRANCH = 3'h1,
    BCC_OP_CALL = 3'h2,
    BCC_OP_CLR_A = 3'h3,
    BCC_OP_CLR_B = 3'h4,
    BCC_OP_CLR_MEM = 3'h5,
    BCC_OP_CMP8 = 3'h6,
    BCC_OP_CMP16 = 3'h7
  } bcc_op_t;

  typedef enum logic [3:0] {
    BCC_COND_UNCONDITIONAL_JUMP_REL = 4'h0,
    BCC_COND_NEVER_JUMP_REL = 4'h1,
    BCC_COND_JUMP_IF_LOWER_OR_SAME = 4'h3,
    BCC_COND_JUMP_IF_LOWER = 4'h5,
    BCC_COND_JUMP_IF_NOT_EQUAL = 4'h6,
    BCC_COND_JUMP_IF_NO_OVERFLOW = 4'h8,
    BCC_COND_JUMP_IF_OVERFLOW = 4'h9,
    BCC_COND_JUMP_IF_PLUS = 4'hA,
    BCC_COND_JUMP_IF_MINUS = 4'hB,
    BCC_COND_JUMP_IF_LESS_SIGNED = 4'hD
  } bcc_cond_t;

  // One machine code, two names
  localparam bcc_cond_t BCC_COND_JUMP_ON_CARRY_SET = BCC_COND_JUMP_IF_LOWER;

  typedef enum logic [1:0] {
    BCC_AM_INHERENT = 2'h0,
    BCC_AM_DIRECT = 2'h1,
    BCC_AM_EXTENDED = 2'h2,
    BCC_AM_INDEXED = 2'h3
  } bcc_amode_t;

  typedef enum logic [2:0] {
    BCC_ST_IDLE = 3'h0,
    BCC_ST_CLR_RD = 3'h1,
    BCC_ST_CLR_WR = 3'h2,
    BCC_ST_PUSH_LO = 3'h3,
    BCC_ST_PUSH_HI = 3'h4
  } bcc_state_t;

  typedef struct packed {
    bcc_op_t op;
    bcc_cond_t cond;
    logic long_form;
    bcc_amode_t amode;
    logic auto_idx;
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] offset;
    logic [ADDR_W-1:0] operand_reg;
    logic [ADDR_W-1:0] mem_operand;
    logic [ADDR_W-1:0] sp;
    logic [ADDR_W-1:0] effective_address;
    logic [ADDR_W-1:0] idx_new;
    logic [DATA_W-1:0] cc;
  } bcc_req_t;

  typedef struct packed {
    logic pc_load;
    logic [ADDR_W-1:0] pc_val;
    logic cc_we;
    logic [DATA_W-1:0] cc_val;
    logic acc_a_clr;
    logic acc_b_clr;
    logic sp_we;
    logic [ADDR_W-1:0] sp_val;
    logic idx_we;
    logic [ADDR_W-1:0] idx_val;
  } bcc_res_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } bcc_flags_t;

endpackage

// ### logic/bcc_cond_eval.sv
module bcc_cond_eval (
  input wire bcc_pkg::bcc_cond_t cond,
  input wire logic [7:0] cc,
  output logic taken,
  output logic known
);
  logic c;
  logic v;
  logic z;
  logic n;

  assign c = cc[bcc_pkg::CC_C];
  assign v = cc[bcc_pkg::CC_V];
  assign z = cc[bcc_pkg::CC_Z];
  assign n = cc[bcc_pkg::CC_N];

  always_comb begin
    known = 1'b1;
    case (cond)
      bcc_pkg::BCC_COND_UNCONDITIONAL_JUMP_REL: taken = 1'b1;
      bcc_pkg::BCC_COND_NEVER_JUMP_REL: taken = 1'b0;
      bcc_pkg::BCC_COND_JUMP_IF_LOWER_OR_SAME: taken = c | z;
      bcc_pkg::BCC_COND_JUMP_IF_LOWER: taken = c;
      bcc_pkg::BCC_COND_JUMP_IF_NOT_EQUAL: taken = ~z;
      bcc_pkg::BCC_COND_JUMP_IF_NO_OVERFLOW: taken = ~v;
      bcc_pkg::BCC_COND_JUMP_IF_OVERFLOW: taken = v;
      bcc_pkg::BCC_COND_JUMP_IF_PLUS: taken = ~n;
      bcc_pkg::BCC_COND_JUMP_IF_MINUS: taken = n;
      bcc_pkg::BCC_COND_JUMP_IF_LESS_SIGNED: taken = n ^ v;
      default: begin
        taken = 1'b0;
        known = 1'b0;
      end
    endcase
  end
endmodule // bcc_cond_eval

// ### logic/bcc_cmp_alu.sv
module bcc_cmp_alu (
  input wire logic wide,
  input wire logic [15:0] reg_val,
  input wire logic [15:0] mem_val,
  output bcc_pkg::bcc_flags_t flags
);
  logic [16:0] sum16;
  logic [8:0] sum8;
  logic [15:0] diff16;
  logic [7:0] diff8;

  // Subtract as add of complement plus one; borrow is the inverted carry
  assign sum16 = {1'b0, reg_val} + {1'b0, ~mem_val} + 17'h00001;
  assign sum8 = {1'b0, reg_val[7:0]} + {1'b0, ~mem_val[7:0]} + 9'h001;
  assign diff16 = sum16[15:0];
  assign diff8 = sum8[7:0];

  always_comb begin
    if (wide) begin
      flags.n = diff16[15];
      flags.z = (diff16 == 16'h0000);
      flags.v = (reg_val[15] ^ mem_val[15]) & (diff16[15] ^ reg_val[15]);
      flags.c = ~sum16[16];
    end else begin
      flags.n = diff8[7];
      flags.z = (diff8 == 8'h00);
      flags.v = (reg_val[7] ^ mem_val[7]) & (diff8[7] ^ reg_val[7]);
      flags.c = ~sum8[8];
    end
  end
endmodule // bcc_cmp_alu

// ### dv/bcc_unit_properties.sv
module bcc_unit_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic req_valid,
  input wire bcc_pkg::bcc_req_t req,
  input wire logic req_ready,
  input wire logic done,
  input wire bcc_pkg::bcc_res_t res,
  input wire logic mem_re,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_r;
  logic en_nxt;
  logic acc;
  logic br_acc;
  logic cmp_acc;
  // Mirror of the enable bit, so accepts are judged like the block does
  always_comb begin
    en_nxt = en_r;
    if (!rst_n) begin
      en_nxt = 1'b1;
    end else if (ce && reg_wr && reg_addr == bcc_pkg::REG_CTRL) begin
      en_nxt = reg_wdata[bcc_pkg::CTRL_EN];
    end
  end
  always_ff @(posedge sys_clk) begin
    en_r <= en_nxt;
  end
  assign acc = ce && req_valid && req_ready && en_r;
  assign br_acc = acc && req.op == bcc_pkg::BCC_OP_BRANCH;
  assign cmp_acc = acc && (req.op == bcc_pkg::BCC_OP_CMP8 || req.op == bcc_pkg::BCC_OP_CMP16);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_push;
    mem_we && mem_addr == $past(req.sp) - 16'h0001 && mem_wdata == $past(req.pc[7:0])
    ##1 mem_we && mem_addr == $past(req.sp, 2) - 16'h0002 && mem_wdata == $past(req.pc[15:8], 2);
  endsequence
  sequence s_clr_mem;
    mem_re && !mem_we && mem_addr == $past(req.effective_address)
    ##1 mem_we && mem_wdata == 8'h00 && mem_addr == $past(req.effective_address, 2)
    ##1 done && res.cc_we && res.cc_val[3:0] == 4'h4;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_CALL_PUSH: assert property (acc && req.op == bcc_pkg::BCC_OP_CALL |=> s_push
    ##1 (done && res.pc_load && res.sp_val == $past(req.sp, 3) - 16'h0002))
    else $error("call push order or stack value wrong");
  AST_CLR_MEM_SEQ: assert property (acc && req.op == bcc_pkg::BCC_OP_CLR_MEM
    && req.amode != bcc_pkg::BCC_AM_INHERENT |=> s_clr_mem)
    else $error("memory clear did not read then write zero");
  AST_BR_CC_KEEP: assert property (br_acc |=> done && !res.cc_we && !res.acc_a_clr && !res.sp_we)
    else $error("branch touched flags or registers");
  AST_BRA_ALWAYS: assert property (br_acc && req.long_form
    && req.cond == bcc_pkg::BCC_COND_UNCONDITIONAL_JUMP_REL
    |=> res.pc_load && res.pc_val == $past(req.pc) + $past(req.offset))
    else $error("unconditional jump target wrong");
  AST_BRN_NOP: assert property (br_acc && req.cond == bcc_pkg::BCC_COND_NEVER_JUMP_REL
    |=> done && !res.pc_load && !res.cc_we)
    else $error("never-jump changed pc or flags");
  AST_LT_BRANCH: assert property (br_acc && req.cond == bcc_pkg::BCC_COND_JUMP_IF_LESS_SIGNED
    |=> res.pc_load == ($past(req.cc[bcc_pkg::CC_N]) ^ $past(req.cc[bcc_pkg::CC_V])))
    else $error("signed less-than decision wrong");
  AST_CLR_FLAGS: assert property (acc && req.op == bcc_pkg::BCC_OP_CLR_A
    && req.amode == bcc_pkg::BCC_AM_INHERENT |=> done && res.acc_a_clr && res.cc_we
    && res.cc_val[3:0] == 4'h4 && res.cc_val[bcc_pkg::CC_H] == $past(req.cc[bcc_pkg::CC_H]))
    else $error("clear flags wrong");
  AST_CMP_NO_WB: assert property (cmp_acc |=> done && res.cc_we
    && !(res.acc_a_clr || res.acc_b_clr || res.sp_we || res.pc_load))
    else $error("compare wrote back an operand");
  AST_CMP_BORROW: assert property (acc && req.op == bcc_pkg::BCC_OP_CMP16
    |=> res.cc_val[bcc_pkg::CC_C] == ($past(req.operand_reg) < $past(req.mem_operand))
    && res.cc_val[bcc_pkg::CC_H] == $past(req.cc[bcc_pkg::CC_H]))
    else $error("wide compare borrow or half-carry wrong");
endmodule // bcc_unit_properties

bind bcc_unit bcc_unit_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .done(done), .res(res), .mem_re(mem_re), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ### dv/tb_bcc_unit.sv
module tb_bcc_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  bcc_pkg::bcc_req_t req = '0;
  logic req_ready, done, mem_re, mem_we, rd_q;
  bcc_pkg::bcc_res_t res;
  logic [15:0] mem_addr, reg_rdata, last_tgt;
  logic [7:0] mem_wdata;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  int fails = 0;
  int cmp_count = 0;
  bcc_pkg::bcc_res_t exp_q[$];
  bcc_pkg::bcc_res_t msk_q[$];
  logic [15:0] rexp_q[$];
  always #4 sys_clk = ~sys_clk;
  bcc_unit u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .res(res), .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp_res(bcc_pkg::bcc_res_t got, bcc_pkg::bcc_res_t e, bcc_pkg::bcc_res_t m);
    cmp_count++;
    if ((got & m) !== (e & m)) begin
      fails++;
      $display("unexpected result at %0t: got %h expected %h", $time, got & m, e & m);
    end
  endtask
  task automatic cmp_reg(logic [15:0] got, logic [15:0] e);
    cmp_count++;
    if (got !== e) begin
      fails++;
      $display("unexpected register data at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  // Outputs are sampled at the edge, before that edge's updates land
  always @(posedge sys_clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp_res(res, bcc_pkg::bcc_res_t'(~res), '1);
      end else begin
        cmp_res(res, exp_q.pop_front(), msk_q.pop_front());
      end
    end
    if (rd_q === 1'b1) begin
      cmp_reg(reg_rdata, rexp_q.size() > 0 ? rexp_q.pop_front() : ~reg_rdata);
    end
    rd_q <= reg_rd;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Valid is left high between requests so back-to-back accepts need no gap
  task automatic issue(bcc_pkg::bcc_req_t r, bcc_pkg::bcc_res_t e, bcc_pkg::bcc_res_t m);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= r;
    @(posedge sys_clk);
    while (req_ready !== 1'b1 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 20) begin
      fails++;
    end
    exp_q.push_back(e);
    msk_q.push_back(m);
  endtask
  task automatic drain();
    req_valid <= 1'b0;
    repeat (6) @(posedge sys_clk);
    cmp_count++;
    if (exp_q.size() != 0) begin
      fails++;
      $display("unexpected missing done at %0t: got %h expected %h", $time, exp_q.size(), 0);
    end
  endtask
  // For reads d is the expected data
  task automatic reg_op(logic wr, logic [1:0] a, logic [15:0] d);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    if (!wr) begin
      rexp_q.push_back(d);
    end
    @(posedge sys_clk);
  endtask
  task automatic reg_idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  function automatic bcc_pkg::bcc_req_t rnd_req(bcc_pkg::bcc_op_t op);
    logic [191:0] b;
    bcc_pkg::bcc_req_t r;
    b = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    r = b[$bits(r)-1:0];
    r.op = op;
    return r;
  endfunction
  function automatic logic [15:0] tgt_of(bcc_pkg::bcc_req_t r);
    return r.pc + (r.long_form ? r.offset : {{8{r.offset[7]}}, r.offset[7:0]});
  endfunction
  function automatic logic hit(bcc_pkg::bcc_cond_t c, logic [7:0] cc);
    logic n, z, v, k;
    n = cc[bcc_pkg::CC_N];
    z = cc[bcc_pkg::CC_Z];
    v = cc[bcc_pkg::CC_V];
    k = cc[bcc_pkg::CC_C];
    case (c)
      bcc_pkg::BCC_COND_UNCONDITIONAL_JUMP_REL: return 1'b1;
      bcc_pkg::BCC_COND_JUMP_IF_LOWER_OR_SAME: return k | z;
      bcc_pkg::BCC_COND_JUMP_ON_CARRY_SET: return k;
      bcc_pkg::BCC_COND_JUMP_IF_NOT_EQUAL: return !z;
      bcc_pkg::BCC_COND_JUMP_IF_NO_OVERFLOW: return !v;
      bcc_pkg::BCC_COND_JUMP_IF_OVERFLOW: return v;
      bcc_pkg::BCC_COND_JUMP_IF_PLUS: return !n;
      bcc_pkg::BCC_COND_JUMP_IF_MINUS: return n;
      bcc_pkg::BCC_COND_JUMP_IF_LESS_SIGNED: return n ^ v;
      default: return 1'b0;
    endcase
  endfunction
  // Narrow operands moved to the top byte so one subtractor serves both widths
  function automatic logic [3:0] cmp_f(logic w, logic [15:0] a, logic [15:0] b);
    logic [15:0] d;
    if (!w) begin
      a = {a[7:0], 8'h00};
      b = {b[7:0], 8'h00};
    end
    d = a - b;
    return {d[15], d == 16'h0000, (a[15] ^ b[15]) & (a[15] ^ d[15]), a < b};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    fails++;
    close_out();
  end
  initial begin
    bcc_pkg::bcc_req_t r;
    bcc_pkg::bcc_res_t e, m;
    logic t;
    void'($urandom(32'h73F301E7));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    reg_op(1'b0, bcc_pkg::REG_STATUS, 16'h0000);
    reg_op(1'b0, bcc_pkg::REG_CTRL, bcc_pkg::CTRL_RESET);
    reg_op(1'b0, bcc_pkg::REG_TARGET, 16'h0000);
    reg_op(1'b0, bcc_pkg::REG_COUNT, 16'h0000);
    reg_idle();
    for (int i = 0; i < 200; i++) begin
      r = rnd_req(bcc_pkg::BCC_OP_BRANCH);
      t = hit(r.cond, r.cc);
      e = '0;
      m = '1;
      e.pc_load = t;
      e.pc_val = t ? tgt_of(r) : r.pc;
      m.cc_val = '0;
      m.sp_val = '0;
      m.idx_val = '0;
      issue(r, e, m);
    end
    drain();
    for (int i = 0; i < 8; i++) begin
      r = rnd_req(bcc_pkg::BCC_OP_CALL);
      e = '0;
      m = '1;
      e.pc_load = 1'b1;
      e.pc_val = tgt_of(r);
      e.sp_we = 1'b1;
      e.sp_val = r.sp - 16'h0002;
      m.cc_val = '0;
      m.idx_val = '0;
      last_tgt = e.pc_val;
      issue(r, e, m);
    end
    drain();
    reg_op(1'b1, bcc_pkg::REG_TARGET, 16'hFFFF);
    reg_op(1'b0, bcc_pkg::REG_TARGET, last_tgt);
    reg_idle();
    for (int k = 0; k < 12; k++) begin
      r = rnd_req(bcc_pkg::bcc_op_t'(3 + k / 4));
      r.amode = bcc_pkg::bcc_amode_t'(k % 4);
      t = (r.op == bcc_pkg::BCC_OP_CLR_MEM) == (r.amode != bcc_pkg::BCC_AM_INHERENT);
      e = '0;
      m = '1;
      e.acc_a_clr = r.op == bcc_pkg::BCC_OP_CLR_A;
      e.acc_b_clr = r.op == bcc_pkg::BCC_OP_CLR_B;
      e.cc_we = t;
      e.cc_val = {2'h0, r.cc[bcc_pkg::CC_H], 5'h04};
      m.cc_val = t ? 8'h2F : 8'h00;
      m.pc_val = '0;
      m.sp_val = '0;
      m.idx_val = '0;
      // Illegal register clears still clear; their flag update is left open
      if (!t && r.op != bcc_pkg::BCC_OP_CLR_MEM) begin
        m.cc_we = 1'b0;
      end
      issue(r, e, m);
    end
    drain();
    // Last call left taken set; last clear was legal
    reg_op(1'b0, bcc_pkg::REG_STATUS, 16'h0002);
    reg_op(1'b1, bcc_pkg::REG_COUNT, 16'h0000);
    reg_idle();
    for (int i = 0; i < 40; i++) begin
      r = rnd_req(i % 2 ? bcc_pkg::BCC_OP_CMP16 : bcc_pkg::BCC_OP_CMP8);
      if (i % 4 < 2) begin
        r.mem_operand = r.operand_reg;
      end
      e = '0;
      m = '1;
      e.cc_we = 1'b1;
      e.cc_val = {r.cc[7:4], cmp_f(r.op == bcc_pkg::BCC_OP_CMP16, r.operand_reg, r.mem_operand)};
      e.idx_we = r.op == bcc_pkg::BCC_OP_CMP16 && r.auto_idx;
      e.idx_val = r.idx_new;
      m.pc_val = '0;
      m.sp_val = '0;
      m.idx_val = e.idx_we ? 16'hFFFF : 16'h0000;
      issue(r, e, m);
    end
    drain();
    reg_op(1'b0, bcc_pkg::REG_COUNT, 16'h0028);
    reg_op(1'b1, bcc_pkg::REG_CTRL, 16'h0000);
    reg_idle();
    // Disabled block must ignore a standing request
    req_valid <= 1'b1;
    repeat (6) @(posedge sys_clk);
    reg_op(1'b1, bcc_pkg::REG_CTRL, 16'h0001);
    // Frozen block ignores both the request and a register write
    ce <= 1'b0;
    reg_op(1'b1, bcc_pkg::REG_CTRL, 16'h00F1);
    repeat (4) @(posedge sys_clk);
    req_valid <= 1'b0;
    ce <= 1'b1;
    reg_op(1'b0, bcc_pkg::REG_CTRL, 16'h0001);
    reg_idle();
    repeat (4) @(posedge sys_clk);
    close_out();
  end
endmodule // tb_bcc_unit
